/* File: hdl/bdic_top.sv */
// base address decode and interrupt capability options of one function set
// assumes a same-clock register master and a same-clock request source
`timescale 1ns/10ps
module bdic_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  input wire logic [63:0] req_addr,
  input wire logic req_io,
  output bdic_pkg::bdic_hit_t hit_o,
  output bdic_pkg::bdic_fn_stat_t [bdic_pkg::NUM_PF-1:0] fn_stat_o,
  output logic [bdic_pkg::NUM_BAR-1:0] bar_active_o,
  output logic rom_active_o
);
  localparam int NB = bdic_pkg::NUM_BAR;
  localparam int NP = bdic_pkg::NUM_PF;

  // ****************************************
  // state
  // ****************************************
  logic [3:0] devcfg_r;
  bdic_pkg::bdic_bar_cfg_t [NB-1:0] bar_cfg_r;
  bdic_pkg::bdic_bar_cfg_t rom_cfg_r;
  logic [31:0] bar_val_r [NB];
  logic [31:0] rom_val_r;
  bdic_pkg::bdic_fn_cfg_t [NP-1:0] fn_cfg_r;
  logic [31:0] rd_nxt;
  bdic_pkg::bdic_hit_t hit_nxt;
  bdic_pkg::bdic_fn_stat_t [NP-1:0] fn_stat;

  bdic_pkg::bdic_bar_cfg_t [NB-1:0] eff;
  logic [NB-1:0] upper_v;
  logic [5:0] up_size [NB];
  logic [31:0] wmask [NB];
  logic [31:0] rd_val [NB];
  logic [NB-1:0] hit_v;
  logic [NB-1:0] eff_en_v;
  logic [NB-1:0] eff_io_v;
  logic [1:0] port_type;
  logic is_leg;
  logic is_ep;
  logic [2:0] max_bars;

  logic [5:0] rom_size;
  logic [31:0] rom_mask;
  logic [31:0] rom_wmask;
  logic rom_claim_en;
  logic rom_hit;
  logic rom_big;
  logic [NP-1:0] nc_v;
  logic [31:0] status;

  assign port_type = devcfg_r[1:0];
  assign is_leg = (port_type == bdic_pkg::PT_LEG);
  assign is_ep = (port_type == bdic_pkg::PT_EP);
  assign max_bars = (port_type == bdic_pkg::PT_RP) ? bdic_pkg::MAX_BAR_RP : bdic_pkg::MAX_BAR_EP;

  // ****************************************
  // legal bar configuration
  // ****************************************
  // user choices that the function type cannot honour are bent to the nearest
  // legal setting rather than refused, so software always sees a valid view
  generate
    for (genvar i = 0; i < NB; i++) begin : g_bar
      logic allowed;
      logic io;
      logic can64;
      logic promote;
      logic is64;
      logic [5:0] lo_sz;
      logic [5:0] hi_sz;
      logic [5:0] sz;
      if (i == 0) begin : g_first
        assign upper_v[i] = 1'b0;
        assign up_size[i] = 6'h0;
      end else begin : g_next
        assign upper_v[i] = eff[i-1].en & eff[i-1].is64;
        assign up_size[i] = eff[i-1].size;
      end
      assign allowed = (3'(i) < max_bars);
      assign io = bar_cfg_r[i].io & is_leg;
      assign can64 = !io && ((3'(i) + 3'h1) < max_bars);
      assign promote = is_ep && bar_cfg_r[i].pref && (3'(i) != bdic_pkg::LAST_BAR);
      assign is64 = can64 && (bar_cfg_r[i].is64 || promote);
      assign lo_sz = (io || is_leg) ? bdic_pkg::SZ_LEG_MIN : bdic_pkg::SZ_MEM_MIN;
      assign hi_sz = is64 ? bdic_pkg::SZ_64_MAX : bdic_pkg::SZ_32_MAX;
      assign sz = (bar_cfg_r[i].size < lo_sz) ? lo_sz :
                  ((bar_cfg_r[i].size > hi_sz) ? hi_sz : bar_cfg_r[i].size);
      assign eff[i] = {sz, bar_cfg_r[i].pref & !io, is64, io,
                       bar_cfg_r[i].en & allowed & !upper_v[i]};
      assign eff_en_v[i] = eff[i].en;
      assign eff_io_v[i] = eff[i].io;

      bdic_bar_slot u_slot (
        .cfg(eff[i]),
        .is_upper(upper_v[i]),
        .upper_size(up_size[i]),
        .lo_val(bar_val_r[i]),
        .hi_val(bar_val_r[(i + 1) % NB]),
        .req_addr(req_addr),
        .req_io(req_io),
        .wmask(wmask[i]),
        .rd_val(rd_val[i]),
        .hit(hit_v[i])
      );

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          bar_cfg_r[i] <= (i == 0) ? bdic_pkg::BAR0CFG_RST : bdic_pkg::BARCFG_RST;
        end else if (reg_wr && reg_addr == bdic_pkg::OFS_BARCFG + 8'(4 * i)) begin
          bar_cfg_r[i] <= reg_wdata[9:0];
        end
      end

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          bar_val_r[i] <= 32'h0;
        end else if (reg_wr && reg_addr == bdic_pkg::OFS_BARVAL + 8'(4 * i)) begin
          bar_val_r[i] <= reg_wdata & wmask[i];
        end
      end

      a_upper_idle: assert property (
        @(posedge clk) disable iff (!rstn)
        upper_v[i] |=> !bar_active_o[i] || !$past(upper_v[i]))
        else $error("upper half of a wide bar shown as a window");
    end
  endgenerate

  // ****************************************
  // expansion rom
  // ****************************************
  // rom window range
  assign rom_size = (rom_cfg_r.size < bdic_pkg::SZ_ROM_MIN) ? bdic_pkg::SZ_ROM_MIN :
                    ((rom_cfg_r.size > bdic_pkg::SZ_ROM_MAX) ? bdic_pkg::SZ_ROM_MAX :
                     rom_cfg_r.size);
  assign rom_mask = (rom_size >= bdic_pkg::SZ_DWORD) ? 32'h0 : (32'hffff_ffff << rom_size);
  // bit 0 is the host's own decode enable, kept writable beside the address
  assign rom_wmask = rom_cfg_r.en ? (rom_mask | 32'h1) : 32'h0;
  assign rom_claim_en = rom_cfg_r.en && rom_val_r[0];
  assign rom_hit = rom_claim_en && !req_io && (req_addr[63:32] == 32'h0) &&
                   ((req_addr[31:0] & rom_mask) == (rom_val_r & rom_mask));
  assign rom_big = rom_cfg_r.en && (rom_size > bdic_pkg::SZ_ROM_REC);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rom_cfg_r <= bdic_pkg::ROMCFG_RST;
    end else if (reg_wr && reg_addr == bdic_pkg::OFS_ROMCFG) begin
      rom_cfg_r <= reg_wdata[9:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rom_val_r <= 32'h0;
    end else if (reg_wr && reg_addr == bdic_pkg::OFS_ROMVAL) begin
      rom_val_r <= reg_wdata & rom_wmask;
    end
  end

  // ****************************************
  // device options and functions
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      devcfg_r <= bdic_pkg::DEVCFG_RST;
    end else if (reg_wr && reg_addr == bdic_pkg::OFS_DEVCFG) begin
      devcfg_r <= reg_wdata[3:0];
    end
  end

  generate
    for (genvar p = 0; p < NP; p++) begin : g_fn
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          fn_cfg_r[p] <= bdic_pkg::FNCFG_RST;
        end else if (reg_wr && reg_addr == bdic_pkg::OFS_FNCFG + 8'(4 * p)) begin
          fn_cfg_r[p] <= reg_wdata[8:0];
        end
      end

      bdic_fn_caps u_caps (
        .cfg(fn_cfg_r[p]),
        .pvm_all(devcfg_r[bdic_pkg::DC_PVM_BIT]),
        .ovt_opt(devcfg_r[bdic_pkg::DC_OVT_BIT]),
        .stat(fn_stat[p])
      );
      assign nc_v[p] = fn_stat[p].noncompliant;

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          fn_stat_o[p] <= '0;
        end else begin
          fn_stat_o[p] <= fn_stat[p];
        end
      end

      a_pasid_intx: assert property (
        @(posedge clk) disable iff (!rstn)
        fn_cfg_r[p].pasid |=> fn_stat_o[p].pin == 3'h0)
        else $error("legacy interrupt pin offered while pasid enabled");

      a_ovt_no_msi: assert property (
        @(posedge clk) disable iff (!rstn)
        devcfg_r[bdic_pkg::DC_OVT_BIT] ##1 devcfg_r[bdic_pkg::DC_OVT_BIT]
        |-> !fn_stat_o[p].msi_present && fn_stat_o[p].mme == 3'h0)
        else $error("msi offered beside on-chip vector table");

      a_nc_flag: assert property (
        @(posedge clk) disable iff (!rstn)
        !fn_cfg_r[p].msi_en && !fn_cfg_r[p].msix_en |=> fn_stat_o[p].noncompliant)
        else $error("function without msi or msix not flagged");
    end
  endgenerate

  // ****************************************
  // request decode
  // ****************************************
  // lowest numbered bar wins an overlap; the rom is consulted last
  always_comb begin
    hit_nxt = '0;
    hit_nxt.valid = req_valid;
    if (req_valid && rom_hit) begin
      hit_nxt.hit = 1'b1;
      hit_nxt.bar = bdic_pkg::ROM_ID;
    end
    for (int i = NB - 1; i >= 0; i--) begin
      if (req_valid && hit_v[i]) begin
        hit_nxt.hit = 1'b1;
        hit_nxt.bar = 3'(i);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hit_o <= '0;
    end else begin
      hit_o <= hit_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bar_active_o <= '0;
      rom_active_o <= 1'b0;
    end else begin
      bar_active_o <= eff_en_v;
      rom_active_o <= rom_cfg_r.en;
    end
  end

  // ****************************************
  // register read
  // ****************************************
  assign status = {14'h0, upper_v, nc_v, rom_big, rom_cfg_r.en, eff_en_v};

  always_comb begin
    rd_nxt = 32'h0;
    if (reg_addr == bdic_pkg::OFS_DEVCFG) begin
      rd_nxt = {28'h0, devcfg_r};
    end
    if (reg_addr == bdic_pkg::OFS_STATUS) begin
      rd_nxt = status;
    end
    if (reg_addr == bdic_pkg::OFS_ROMCFG) begin
      rd_nxt = {22'h0, rom_cfg_r};
    end
    if (reg_addr == bdic_pkg::OFS_ROMVAL) begin
      rd_nxt = rom_val_r & rom_wmask;
    end
    for (int i = 0; i < NB; i++) begin
      if (reg_addr == bdic_pkg::OFS_BARCFG + 8'(4 * i)) begin
        rd_nxt = {22'h0, bar_cfg_r[i]};
      end
      if (reg_addr == bdic_pkg::OFS_BARVAL + 8'(4 * i)) begin
        rd_nxt = rd_val[i];
      end
    end
    for (int p = 0; p < NP; p++) begin
      if (reg_addr == bdic_pkg::OFS_FNCFG + 8'(4 * p)) begin
        rd_nxt = {23'h0, fn_cfg_r[p]};
      end
      if (reg_addr == bdic_pkg::OFS_FNSTAT + 8'(4 * p)) begin
        rd_nxt = {23'h0, fn_stat[p]};
      end
    end
  end

  // data held between reads keeps the bus quiet for power and for probing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_rp_two_bars: assert property (
    @(posedge clk) disable iff (!rstn)
    port_type == bdic_pkg::PT_RP ##1 port_type == bdic_pkg::PT_RP
    |-> bar_active_o[NB-1:2] == '0)
    else $error("root port shows more than two bars");

  a_io_legacy: assert property (
    @(posedge clk) disable iff (!rstn)
    eff_io_v != '0 |-> is_leg && (eff_io_v & {eff[5].is64, eff[4].is64, eff[3].is64,
                                   eff[2].is64, eff[1].is64, eff[0].is64}) == '0)
    else $error("io bar outside legacy endpoint or wide");

  a_io_no_mem: assert property (
    @(posedge clk) disable iff (!rstn)
    req_valid && req_io && eff_io_v == '0 |=> hit_o.valid && !hit_o.hit)
    else $error("io request claimed with no io bar");

  a_disabled_quiet: assert property (
    @(posedge clk) disable iff (!rstn)
    req_valid && eff_en_v == '0 && !rom_claim_en |=> hit_o.valid && !hit_o.hit)
    else $error("request claimed with every window disabled");

  a_pref_wide: assert property (
    @(posedge clk) disable iff (!rstn)
    is_ep && bar_cfg_r[0].en && bar_cfg_r[0].pref |-> eff[0].is64 && eff[0].en)
    else $error("prefetchable endpoint bar left narrow");

  a_min_window: assert property (
    @(posedge clk) disable iff (!rstn)
    eff[0].en |-> eff[0].size >= (is_leg ? bdic_pkg::SZ_LEG_MIN : bdic_pkg::SZ_MEM_MIN))
    else $error("bar window below its minimum");

  a_rom_range: assert property (
    @(posedge clk) disable iff (!rstn)
    rom_size >= bdic_pkg::SZ_ROM_MIN && rom_size <= bdic_pkg::SZ_ROM_MAX)
    else $error("rom window outside 2 KB to 4 GB");

  a_size_readback: assert property (
    @(posedge clk) disable iff (!rstn)
    reg_wr && reg_addr == bdic_pkg::OFS_BARVAL && reg_wdata == 32'hffff_ffff &&
    eff[0].en && !eff[0].io ##1 reg_rd && reg_addr == bdic_pkg::OFS_BARVAL && $stable(eff[0])
    |=> reg_rdata == (wmask[0] | {28'h0, eff[0].pref, eff[0].is64, 2'h0}))
    else $error("bar sizing readback wrong");

  a_hit_timing: assert property (
    @(posedge clk) disable iff (!rstn)
    req_valid != $past(req_valid) |-> ##1 hit_o.valid == $past(req_valid))
    else $error("decode answer not one cycle after request");
endmodule

/* File: hdl/bdic_pkg.sv */
// constants, field layouts and carrier types of the bar decode block
// assumes a single 50 MHz clock and a plain register port
// Operation
// - endpoint: six 32-bit or three 64-bit BARs
// - root port: two 32-bit or one 64-bit BAR
// - 32-bit BAR: 128 B to 2 GB
// - 64-bit BAR: memory only, up to 8 EB
// - disabled BAR claims and offers nothing
// - I/O BAR: 32-bit, unprefetchable, legacy only
// - 64-bit BAR swallows the following BAR
// - I/O window at least 16 bytes
// - expansion ROM window 2 KB to 4 GB
// - expansion ROM above 16 MB is flagged
// - BAR claims only its own space type
// - prefetchable only for memory windows
// - endpoint prefetchable BARs except last are 64-bit
// - minimum memory window 128 B, legacy 16 B
// - interrupt pin setting selects legacy mapping
// - PASID enabled blocks legacy interrupts
// - per-function MSI capability presence option
// - on-chip vector table removes MSI capability
// - multiple message setting sets vector request
// - per-vector masking is one global option
// - neither MSI nor MSI-X flagged non-compliant
package bdic_pkg;
  localparam int NUM_BAR = 6;
  localparam int NUM_PF = 4;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_DEVCFG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BARCFG = 8'h10;
  localparam logic [7:0] OFS_ROMCFG = 8'h30;
  localparam logic [7:0] OFS_BARVAL = 8'h40;
  localparam logic [7:0] OFS_ROMVAL = 8'h58;
  localparam logic [7:0] OFS_FNCFG = 8'h60;
  localparam logic [7:0] OFS_FNSTAT = 8'h70;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam logic [1:0] PT_EP = 2'h0;
  localparam logic [1:0] PT_LEG = 2'h1;
  localparam logic [1:0] PT_RP = 2'h2;
  localparam int DC_PVM_BIT = 2;
  localparam int DC_OVT_BIT = 3;
  localparam logic [3:0] DEVCFG_RST = 4'h0;
  localparam int ST_ROM_ACT = 6;
  localparam int ST_ROM_BIG = 7;
  localparam int ST_NC_LSB = 8;
  localparam int ST_UP_LSB = 12;
  localparam logic [9:0] BAR0CFG_RST = 10'h111;
  localparam logic [9:0] BARCFG_RST = 10'h070;
  localparam logic [9:0] ROMCFG_RST = 10'h0b0;
  localparam logic [8:0] FNCFG_RST = 9'h108;
  localparam logic [2:0] MAX_BAR_EP = 3'h6;
  localparam logic [2:0] MAX_BAR_RP = 3'h2;
  localparam logic [2:0] LAST_BAR = 3'h5;
  localparam logic [2:0] ROM_ID = 3'h6;
  localparam logic [2:0] PIN_MAX = 3'h4;
  localparam logic [2:0] MME_MAX = 3'h5;

  // window sizes as log2 of bytes
  localparam logic [5:0] SZ_MEM_MIN = 6'h07;
  localparam logic [5:0] SZ_LEG_MIN = 6'h04;
  localparam logic [5:0] SZ_32_MAX = 6'h1f;
  localparam logic [5:0] SZ_64_MAX = 6'h3f;
  localparam logic [5:0] SZ_ROM_MIN = 6'h0b;
  localparam logic [5:0] SZ_ROM_MAX = 6'h20;
  localparam logic [5:0] SZ_ROM_REC = 6'h18;
  localparam logic [5:0] SZ_DWORD = 6'h20;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic [5:0] size;
    logic pref;
    logic is64;
    logic io;
    logic en;
  } bdic_bar_cfg_t;

  typedef struct packed {
    logic msix_en;
    logic pasid;
    logic [2:0] mme;
    logic msi_en;
    logic [2:0] pin;
  } bdic_fn_cfg_t;

  typedef struct packed {
    logic noncompliant;
    logic pvm;
    logic [2:0] mme;
    logic msi_present;
    logic [2:0] pin;
  } bdic_fn_stat_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [2:0] bar;
  } bdic_hit_t;
endpackage

/* File: hdl/bdic_bar_slot.sv */
// one base address register: write mask, read view and address match
// assumes its configuration has already been made legal by the caller
`timescale 1ns/10ps
module bdic_bar_slot (
  input wire bdic_pkg::bdic_bar_cfg_t cfg,
  input wire logic is_upper,
  input wire logic [5:0] upper_size,
  input wire logic [31:0] lo_val,
  input wire logic [31:0] hi_val,
  input wire logic [63:0] req_addr,
  input wire logic req_io,
  output logic [31:0] wmask,
  output logic [31:0] rd_val,
  output logic hit
);
  logic [31:0] lo_mask;
  logic [31:0] hi_mask;
  logic [31:0] attr;
  logic [63:0] amask;
  logic [63:0] base;

  always_comb begin
    lo_mask = (cfg.size >= bdic_pkg::SZ_DWORD) ? 32'h0 : (32'hffff_ffff << cfg.size);
    hi_mask = 32'hffff_ffff;
    if (upper_size >= bdic_pkg::SZ_DWORD) begin
      hi_mask = 32'hffff_ffff << (upper_size - bdic_pkg::SZ_DWORD);
    end
    attr = cfg.io ? 32'h1 : {28'h0, cfg.pref, cfg.is64, 2'h0};
    amask = 64'hffff_ffff_ffff_ffff << cfg.size;
    base = {(cfg.is64 ? hi_val : 32'h0), lo_val} & amask;
    wmask = is_upper ? hi_mask : (cfg.en ? lo_mask : 32'h0);
    rd_val = is_upper ? (lo_val & hi_mask) : (cfg.en ? ((lo_val & lo_mask) | attr) : 32'h0);
    hit = cfg.en && (req_io == cfg.io) && ((req_addr & amask) == base);
  end
endmodule

/* File: hdl/bdic_fn_caps.sv */
// interrupt capability view of one physical function
// assumes the global options are shared by all functions
`timescale 1ns/10ps
module bdic_fn_caps (
  input wire bdic_pkg::bdic_fn_cfg_t cfg,
  input wire logic pvm_all,
  input wire logic ovt_opt,
  output bdic_pkg::bdic_fn_stat_t stat
);
  logic msi_on;

  always_comb begin
    msi_on = cfg.msi_en && !ovt_opt;
    stat.msi_present = msi_on;
    stat.pin = (cfg.pasid || cfg.pin > bdic_pkg::PIN_MAX) ? 3'h0 : cfg.pin;
    stat.mme = !msi_on ? 3'h0 : (cfg.mme > bdic_pkg::MME_MAX ? bdic_pkg::MME_MAX : cfg.mme);
    stat.pvm = msi_on && pvm_all;
    stat.noncompliant = !msi_on && !cfg.msix_en;
  end
endmodule

/* File: test/bdic_host.sv */
// host configuration model: register master and decode request source
// assumes the device answers a read in the cycle after the strobe
`timescale 1ns/10ps
module bdic_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata,
  output logic req_valid,
  output logic [63:0] req_addr,
  output logic req_io,
  input wire bdic_pkg::bdic_hit_t hit_o
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    req_valid = 1'b0;
    req_addr = 64'h0;
    req_io = 1'b0;
  end

  // ****************************************
  // register cycles
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // stale data must not look valid once the strobe is gone
    reg_wdata <= ~d;
  endtask

  // write then read of one address with no idle cycle between the strobes
  task automatic wrrd(input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // ****************************************
  // decode requests
  // ****************************************
  task automatic req(input logic [63:0] a, input logic io, output bdic_pkg::bdic_hit_t h);
    @(posedge clk);
    req_addr <= a;
    req_io <= io;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    req_addr <= ~a;
    @(negedge clk);
    h = hit_o;
  endtask
endmodule

/* File: test/testbench.sv */
// self-checking bench for the bar decode and capability block
// assumes the host model drives every design input except clk and rstn
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic req_valid;
  logic [63:0] req_addr;
  logic req_io;
  bdic_pkg::bdic_hit_t hit_o;
  bdic_pkg::bdic_fn_stat_t [bdic_pkg::NUM_PF-1:0] fn_stat;
  logic [5:0] bar_act;
  logic rom_act;
  integer seed = 34;
  int bad_count = 0;
  int cmp_count = 0;
  int e;
  logic [31:0] d;
  logic [31:0] m;
  logic [31:0] b;
  logic [8:0] f;
  logic [1:0] g;
  bdic_pkg::bdic_hit_t h;

  always #10 clk = ~clk;

  bdic_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid), .req_addr(req_addr),
    .req_io(req_io), .hit_o(hit_o));

  bdic_top dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_addr(req_addr), .req_io(req_io), .hit_o(hit_o), .fn_stat_o(fn_stat),
    .bar_active_o(bar_act), .rom_active_o(rom_act));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    host.rd(a, d);
    chk(d, x);
  endtask

  task automatic settle;
    repeat (2) @(negedge clk);
  endtask

  // sizing: write all ones and read back the window mask
  task automatic sz(input int i, input logic [31:0] cfg, input logic [31:0] x);
    host.wr(8'(bdic_pkg::OFS_BARCFG + 4 * i), cfg);
    host.wrrd(8'(bdic_pkg::OFS_BARVAL + 4 * i), 32'hffffffff, d);
    chk(d, x);
  endtask

  task automatic rom(input logic [31:0] cfg, input logic [31:0] x, input logic [1:0] s);
    host.wr(bdic_pkg::OFS_ROMCFG, cfg);
    host.wr(bdic_pkg::OFS_ROMVAL, 32'hffffffff);
    rchk(bdic_pkg::OFS_ROMVAL, x);
    host.rd(bdic_pkg::OFS_STATUS, d);
    chk({rom_act, d[7:6]}, {s[0], s});
  endtask

  // o[0] global masking, o[1] on-chip vector table option
  function automatic logic [8:0] fexp(input logic [8:0] c, input logic [1:0] o);
    logic [2:0] pin;
    logic msi;
    pin = (c[7] || c[2:0] > 3'h4) ? 3'h0 : c[2:0];
    msi = c[3] & ~o[1];
    // masking and vector count are only offered where msi is present
    return {~(msi | c[8]), o[0] & msi, msi ? ((c[6:4] > 3'h5) ? 3'h5 : c[6:4]) : 3'h0,
            msi, pin};
  endfunction

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // the sequence needs a few thousand cycles at most
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    settle();
    chk(bar_act, 6'h01);
    rchk(bdic_pkg::OFS_FNCFG, 32'(bdic_pkg::FNCFG_RST));
    sz(0, 32'(bdic_pkg::BAR0CFG_RST), 32'hfffe0000);
    host.wr(8'h40, 32'h12345678);
    rchk(8'h40, 32'h12340000);
    b = $random(seed);
    host.req({32'h0, 32'h12340000 | (b & 32'h1ffff)}, 1'b0, h);
    chk(h, 5'h18);
    host.req({32'h0, 32'h12340000 | (b & 32'h1ffff)}, 1'b1, h);
    chk(h, 5'h10);
    host.wr(8'h10, 32'h110);
    settle();
    chk(bar_act, 6'h00);
    rchk(8'h40, 32'h0);
    host.req(64'h12340000, 1'b0, h);
    chk(h, 5'h10);
    // random window sizes, both clamp ends forced first
    for (int k = 0; k < 10; k++) begin
      e = $unsigned($random(seed)) % 64;
      if (k < 2) e = k ? 63 : 0;
      m = 32'hffffffff << ((e < 7) ? 7 : (e > 31) ? 31 : e);
      sz(1, 32'(e << 4) | 32'h1, m);
      b = $random(seed);
      host.wr(8'h44, b);
      rchk(8'h44, b & m);
      host.req({32'h0, (b & m) | ($random(seed) & ~m)}, 1'b0, h);
      chk(h, 5'h19);
      host.req({32'h0, (b & m) ^ (~m + 32'h1)}, 1'b0, h);
      chk(h, 5'h10);
    end
    host.wr(8'h00, 32'h1);
    sz(1, 32'h001, 32'hfffffff0);
    sz(0, 32'h003, 32'hfffffff1);
    host.wr(8'h40, 32'h1000);
    host.req(64'h1004, 1'b1, h);
    chk(h, 5'h18);
    host.req(64'h1004, 1'b0, h);
    chk(h, 5'h10);
    host.wr(8'h00, 32'h0);
    rchk(8'h40, 32'h1000);
    host.wr(8'h1c, 32'h071);
    sz(2, 32'h3f5, 32'h4);
    host.wr(8'h4c, 32'hffffffff);
    rchk(8'h4c, 32'h80000000);
    chk(bar_act, 6'h07);
    host.rd(bdic_pkg::OFS_STATUS, d);
    chk(d[17:12], 6'h08);
    host.req(64'h8000000000001234, 1'b0, h);
    chk(h, 5'h1a);
    host.req(64'h8000000000001234, 1'b1, h);
    chk(h, 5'h10);
    for (int i = 0; i < 6; i++) host.wr(8'(8'h10 + 4 * i), 32'h071);
    settle();
    chk(bar_act, 6'h3f);
    host.wr(8'h00, 32'h2);
    settle();
    chk(bar_act, 6'h03);
    host.wr(8'h00, 32'h0);
    sz(4, 32'h079, 32'hffffff8c);
    settle();
    chk(bar_act, 6'h1f);
    host.wr(8'h00, 32'h1);
    sz(4, 32'h079, 32'hffffff88);
    host.wr(8'h00, 32'h0);
    host.wr(8'h20, 32'h071);
    sz(5, 32'h079, 32'hffffff88);
    sz(0, 32'h079, 32'hffffff8c);
    rom(32'h0b1, 32'hfffff801, 2'b01);
    rom(32'h181, 32'hff000001, 2'b01);
    rom(32'h191, 32'hfe000001, 2'b11);
    rom(32'h3f1, 32'h00000001, 2'b11);
    rom(32'h180, 32'h0, 2'b00);
    // interrupt options, corner cases first then random
    for (int k = 0; k < 12; k++) begin
      f = 9'($random(seed));
      g = 2'($random(seed));
      if (k == 0) f = 9'h089;
      if (k == 1) g = 2'h2;
      if (k == 2) f = 9'h075;
      host.wr(8'h00, {28'h0, g, 2'h0});
      host.wr(8'(8'h60 + 4 * (k % 4)), 32'(f));
      settle();
      chk(fn_stat[k % 4], fexp(f, g));
      rchk(8'(8'h70 + 4 * (k % 4)), 32'(fexp(f, g)));
    end
    wrap_up();
  end
endmodule
